// ===== rtl/bmrd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// One master's address decoder; combinational
module bmrd_decode (
	input wire logic [bmrd_pkg::ADDR_W-1:0] addr,
	input wire logic remap,
	input wire logic boot_rom,
	output logic [2:0] slave,
	output logic [bmrd_pkg::ADDR_W-1:0] slave_addr,
	output logic hit
);
	import bmrd_pkg::*;

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Boot window goes first; fixed regions always decode too
	always_comb begin
		slave = SLV_NONE;
		slave_addr = addr;
		hit = 1'b0;
		if (in_range(addr, BOOT_BASE, BOOT_LAST)) begin
			hit = 1'b1;
			if (remap) begin
				slave = SLV_SRAM;
				slave_addr = SRAM_BASE | addr;
			end else if (boot_rom) begin
				slave = SLV_ROM;
				slave_addr = ROM_BASE | addr;
			end else begin
				slave = SLV_EXT;
				slave_addr = CHIP_SEL0_BASE | addr;
			end
		end else if (in_range(addr, SRAM_BASE, SRAM_LAST)) begin
			hit = 1'b1;
			slave = SLV_SRAM;
		end else if (in_range(addr, ROM_BASE, ROM_LAST)) begin
			hit = 1'b1;
			slave = SLV_ROM;
		end else if (in_range(addr, EXT_BASE, EXT_LAST)) begin
			hit = 1'b1;
			slave = SLV_EXT;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/bmrd_pkg.sv
package bmrd_pkg;
	// Bus geometry
	localparam int ADDR_W = 32;
	localparam int NUM_MASTERS = 5;
	localparam int NUM_SLAVES = 5;

	// Boot window and fixed bases
	localparam logic [31:0] BOOT_BASE = 32'h0000_0000;
	localparam logic [31:0] BOOT_LAST = 32'h000F_FFFF;
	localparam logic [31:0] SRAM_BASE = 32'h0030_0000;
	localparam logic [31:0] SRAM_LAST = 32'h0032_7FFF;
	localparam logic [31:0] ROM_BASE = 32'h0040_0000;
	localparam logic [31:0] ROM_LAST = 32'h004F_FFFF;
	localparam logic [31:0] EXT_BASE = 32'h1000_0000;
	localparam logic [31:0] EXT_LAST = 32'h8FFF_FFFF;
	localparam logic [31:0] CHIP_SEL0_BASE = 32'h1000_0000;

	// Internal SRAM size after reset, all on the bus side
	localparam int SRAM_KBYTES = 160;

	// Slave numbers of the matrix
	localparam logic [2:0] SLV_ROM = 3'h0;
	localparam logic [2:0] SLV_SRAM = 3'h1;
	localparam logic [2:0] SLV_EXT = 3'h3;
	localparam logic [2:0] SLV_NONE = 3'h7;

	// Static memory controller defaults for external boot
	localparam logic [4:0] MEMCTL_BUS_W = 5'h10;
	localparam logic MEMCTL_BYTE_SELECT = 1'b1;
	localparam logic MEMCTL_RW_BY_CS = 1'b1;

	// Slow clock after external boot
	localparam int SLOW_CLK_HZ = 32768;

	// Boot target
	typedef enum logic [1:0] {
		BMRD_BOOT_EXT = 2'b00,
		BMRD_BOOT_ROM = 2'b01,
		BMRD_BOOT_SRAM = 2'b10
	} bmrd_boot_t;
endpackage

// ===== rtl/bmrd_top.sv
// Functional notes
// - Boot always fetches from address zero
// - Zero to 0x000FFFFF routes to boot target
// - Boot pin high maps ROM at zero
// - Boot pin low maps chip select zero
// - Per-master remap puts SRAM at zero
// - Remap overrides boot pin choice
// - Other memories stay at normal bases
// - External boot runs on slow clock
// - External boot: byte select, 16-bit, CS-qualified
// - External accesses go to slave three
// - ROM always at its fixed base
// - All 160 Kbytes SRAM on bus after reset
`timescale 1ns/1ps
`default_nettype none
module bmrd_top #(
	parameter int MASTERS = bmrd_pkg::NUM_MASTERS
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic boot_select_pin,
	input wire logic [MASTERS-1:0] remap_set,
	input wire logic [MASTERS-1:0] remap_clr,
	input wire logic [MASTERS*bmrd_pkg::ADDR_W-1:0] m_addr,
	output logic [MASTERS*3-1:0] m_slave,
	output logic [MASTERS*bmrd_pkg::ADDR_W-1:0] m_slave_addr,
	output logic [MASTERS-1:0] m_hit,
	output logic [MASTERS-1:0] remap_ff,
	output logic boot_rom_ff,
	output logic boot_valid_ff,
	output logic slow_clock_boot_ff,
	output logic [4:0] memctl_bus_width_ff,
	output logic memctl_byte_select_ff,
	output logic memctl_rw_by_cs_ff,
	output logic [7:0] sram_ahb_kbytes_ff
);
	import bmrd_pkg::*;

	// Three-stage synchroniser for the boot strap pin
	// Runs through reset so it already holds the pin level at release;
	// clearing it would let a stale zero be latched as the strap
	logic [2:0] pin_sync_ff;
	always_ff @(posedge clock) begin
		pin_sync_ff <= {pin_sync_ff[1:0], boot_select_pin};
	end

	// Strap is caught once, on the first agreeing cycle after in_reset_ff clears, which is one edge after release
	logic in_reset_ff;
	always_ff @(posedge clock) begin
		if (!nrst)
			in_reset_ff <= 1'b1;
		else
			in_reset_ff <= 1'b0;
	end

	// Latched only when stages agree, then held until next reset
	logic strap_ok;
	assign strap_ok = pin_sync_ff[1] == pin_sync_ff[2];
	always_ff @(posedge clock) begin
		if (!nrst) begin
			boot_rom_ff <= 1'b0;
			boot_valid_ff <= 1'b0;
		end else if (!boot_valid_ff && !in_reset_ff && strap_ok) begin
			boot_rom_ff <= pin_sync_ff[2];
			boot_valid_ff <= 1'b1;
		end
	end

	// Per-master remap; set wins over a clear in the same cycle
	logic [MASTERS-1:0] nxt_remap;
	always_comb begin
		nxt_remap = (remap_ff & ~remap_clr) | remap_set;
	end
	always_ff @(posedge clock) begin
		if (!nrst)
			remap_ff <= '0;
		else
			remap_ff <= nxt_remap;
	end

	// Reset configuration handed to clocking and memory controller
	always_ff @(posedge clock) begin
		if (!nrst) begin
			slow_clock_boot_ff <= 1'b0;
			memctl_bus_width_ff <= MEMCTL_BUS_W;
			memctl_byte_select_ff <= MEMCTL_BYTE_SELECT;
			memctl_rw_by_cs_ff <= MEMCTL_RW_BY_CS;
			sram_ahb_kbytes_ff <= 8'(SRAM_KBYTES);
		end else if (boot_valid_ff == 1'b0 && !in_reset_ff && strap_ok) begin
			slow_clock_boot_ff <= ~pin_sync_ff[2];
			memctl_bus_width_ff <= MEMCTL_BUS_W;
			memctl_byte_select_ff <= MEMCTL_BYTE_SELECT;
			memctl_rw_by_cs_ff <= MEMCTL_RW_BY_CS;
			sram_ahb_kbytes_ff <= 8'(SRAM_KBYTES);
		end
	end

	// Masters not remapped stall in the boot window until the strap is known
	logic boot_rom_eff;
	assign boot_rom_eff = boot_rom_ff;

	// One decoder per master; hit suppressed in boot window before strap unless that master is remapped
	genvar gi;
	generate
		for (gi = 0; gi < MASTERS; gi++) begin : g_m
			logic [2:0] sl;
			logic [ADDR_W-1:0] sa;
			logic h;
			logic in_boot;
			bmrd_decode u_dec (
				.addr(m_addr[gi*ADDR_W +: ADDR_W]),
				.remap(remap_ff[gi]),
				.boot_rom(boot_rom_eff),
				.slave(sl),
				.slave_addr(sa),
				.hit(h)
			);
			assign in_boot = m_addr[gi*ADDR_W +: ADDR_W] <= BOOT_LAST;
			// Address zero reaches the selected memory once the strap is captured
			assign m_slave[gi*3 +: 3] = sl;
			assign m_slave_addr[gi*ADDR_W +: ADDR_W] = sa;
			assign m_hit[gi] = h && (boot_valid_ff || !in_boot || remap_ff[gi]);

			rom_boot_a: assert property (@(posedge clock) disable iff (!nrst)
				(m_addr[gi*ADDR_W +: ADDR_W] <= BOOT_LAST && !remap_ff[gi] && boot_rom_ff)
				|-> m_slave[gi*3 +: 3] == SLV_ROM)
				else $error("boot window not on ROM");
			ext_boot_a: assert property (@(posedge clock) disable iff (!nrst)
				(m_addr[gi*ADDR_W +: ADDR_W] <= BOOT_LAST && !remap_ff[gi] && !boot_rom_ff)
				|-> m_slave[gi*3 +: 3] == SLV_EXT)
				else $error("boot window not on external memory");
			remap_sram_a: assert property (@(posedge clock) disable iff (!nrst)
				(m_addr[gi*ADDR_W +: ADDR_W] <= BOOT_LAST && remap_ff[gi])
				|-> m_slave[gi*3 +: 3] == SLV_SRAM)
				else $error("remapped window not on SRAM");
			rom_fixed_a: assert property (@(posedge clock) disable iff (!nrst)
				(m_addr[gi*ADDR_W +: ADDR_W] >= ROM_BASE && m_addr[gi*ADDR_W +: ADDR_W] <= ROM_LAST)
				|-> m_slave[gi*3 +: 3] == SLV_ROM && m_hit[gi])
				else $error("ROM base not decoded");
			ext_slave_a: assert property (@(posedge clock) disable iff (!nrst)
				(m_addr[gi*ADDR_W +: ADDR_W] >= EXT_BASE && m_addr[gi*ADDR_W +: ADDR_W] <= EXT_LAST)
				|-> m_slave[gi*3 +: 3] == SLV_EXT)
				else $error("external access off slave three");
		end
	endgenerate

	// Strap captured within a few cycles of release and then stays
	sequence rel_s;
		$rose(nrst);
	endsequence
	strap_capture_a: assert property (@(posedge clock)
		rel_s |-> ##[1:6] boot_valid_ff)
		else $error("boot strap not captured");
	strap_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		boot_valid_ff |=> $stable(boot_rom_ff) && boot_valid_ff)
		else $error("boot strap changed after capture");
	remap_reset_a: assert property (@(posedge clock)
		!nrst |=> remap_ff == '0)
		else $error("remap not cleared by reset");
	slow_boot_a: assert property (@(posedge clock) disable iff (!nrst)
		boot_valid_ff |-> slow_clock_boot_ff == !boot_rom_ff)
		else $error("slow clock flag wrong");
	memctl_default_a: assert property (@(posedge clock) disable iff (!nrst)
		memctl_bus_width_ff == MEMCTL_BUS_W && memctl_byte_select_ff && memctl_rw_by_cs_ff)
		else $error("memory controller default wrong");
endmodule
`default_nettype wire

// ===== testbench/bmrd_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Bus masters: each one holds its address until told to move
module bmrd_master_model (
	input wire logic clock,
	input wire logic go,
	input wire logic [2:0] idx,
	input wire logic [31:0] addr,
	output logic [159:0] m_addr
);
	// Idle masters park on an unmapped address so they never look like a hit
	initial begin
		m_addr = {5{32'h9000_0000}};
	end
	// A new address lands on the edge after the request
	always @(posedge clock) begin
		if (go) begin
			m_addr[idx*32+:32] <= addr;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/boot_memory_remap_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module boot_memory_remap_decoder_tb;
	import bmrd_pkg::*;
	typedef struct {int m; logic [2:0] s; logic [31:0] a; logic h;} bmrd_note_t;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic pin = 1'b1;
	logic go = 1'b0;
	logic [2:0] idx = 3'h0;
	logic [31:0] addr = 32'h0;
	logic [4:0] remap_set = 5'h0;
	logic [4:0] remap_clr = 5'h0;
	logic [159:0] m_addr;
	logic [14:0] m_slave;
	logic [159:0] m_slave_addr;
	logic [4:0] m_hit, remap_ff;
	logic boot_rom_ff, boot_valid_ff, slow_ff, bsel_ff, rwcs_ff;
	logic [4:0] bw_ff;
	logic [7:0] kb_ff;
	logic [15:0] lfsr;
	logic [31:0] off;
	int n_mismatch = 0;
	int compares = 0;
	int m;
	bmrd_note_t q[$];
	bmrd_note_t n;
	bmrd_master_model i_masters (.clock(clock), .go(go), .idx(idx), .addr(addr), .m_addr(m_addr));
	bmrd_top i_dut (.clock(clock), .nrst(nrst), .boot_select_pin(pin), .remap_set(remap_set),
		.remap_clr(remap_clr), .m_addr(m_addr), .m_slave(m_slave), .m_slave_addr(m_slave_addr),
		.m_hit(m_hit), .remap_ff(remap_ff), .boot_rom_ff(boot_rom_ff),
		.boot_valid_ff(boot_valid_ff), .slow_clock_boot_ff(slow_ff), .memctl_bus_width_ff(bw_ff),
		.memctl_byte_select_ff(bsel_ff), .memctl_rw_by_cs_ff(rwcs_ff), .sram_ahb_kbytes_ff(kb_ff));
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Decode is combinational, so results are settled by the falling edge
	always @(negedge clock) begin
		while (q.size() > 0) begin
			n = q.pop_front();
			chk("slave", {29'h0, n.s}, {29'h0, m_slave[n.m*3+:3]});
			chk("hit", {31'h0, n.h}, {31'h0, m_hit[n.m]});
			if (n.h) chk("slave_addr", n.a, m_slave_addr[n.m*32+:32]);
		end
	end
	task automatic send(int mi, logic [31:0] a, logic [2:0] s, logic [31:0] ea, logic h);
		idx = mi[2:0];
		addr = a;
		go = 1'b1;
		@(posedge clock);
		#1;
		go = 1'b0;
		q.push_back('{mi, s, ea, h});
		@(posedge clock);
		#1;
	endtask
	task automatic step();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		off = {12'h000, lfsr[3:0], lfsr};
		m = lfsr % 5;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Bounded wait for the strap capture; a hang ends the run as a failure
	task automatic boot(logic p);
		nrst = 1'b0;
		pin = p;
		repeat (6) @(posedge clock);
		#1;
		remap_set = 5'h0;
		nrst = 1'b1;
		for (int i = 0; i < 20 && boot_valid_ff !== 1'b1; i++) @(posedge clock);
		#1;
		if (boot_valid_ff !== 1'b1) begin
			n_mismatch++;
			conclude();
		end
	endtask
	initial begin
		lfsr = 16'h9BE7;
		boot(1'b1);
		step();
		send(0, 32'h0, SLV_ROM, ROM_BASE, 1'b1);
		send(0, off, SLV_ROM, ROM_BASE | off, 1'b1);
		send(1, BOOT_LAST, SLV_ROM, ROM_BASE | BOOT_LAST, 1'b1);
		send(2, ROM_BASE + 32'h10, SLV_ROM, ROM_BASE + 32'h10, 1'b1);
		send(3, EXT_BASE, SLV_EXT, EXT_BASE, 1'b1);
		send(4, SRAM_BASE + 32'h4, SLV_SRAM, SRAM_BASE + 32'h4, 1'b1);
		send(0, 32'h9000_0000, SLV_NONE, 32'h0, 1'b0);
		chk("sram_kbytes", 32'h0A0, {24'h0, kb_ff});
		$display("test rom boot done");
		step();
		remap_set[m] = 1'b1;
		@(posedge clock);
		#1;
		remap_set = 5'h0;
		send(m, off, SLV_SRAM, SRAM_BASE | off, 1'b1);
		send((m + 1) % 5, off, SLV_ROM, ROM_BASE | off, 1'b1);
		remap_clr[m] = 1'b1;
		@(posedge clock);
		#1;
		remap_clr = 5'h0;
		send(m, off, SLV_ROM, ROM_BASE | off, 1'b1);
		remap_set = 5'h1;
		$display("test remap done");
		boot(1'b0);
		remap_set = 5'h0;
		pin = 1'b1;
		step();
		chk("remap", 32'h0, {27'h0, remap_ff});
		send(0, off, SLV_EXT, CHIP_SEL0_BASE | off, 1'b1);
		// Software never speeds the clocks up here, so the slow request must stand
		chk("slow_clock", 32'h1, {31'h0, slow_ff});
		chk("bus_width", 32'h10, {27'h0, bw_ff});
		chk("byte_sel", 32'h1, {31'h0, bsel_ff});
		chk("rw_by_cs", 32'h1, {31'h0, rwcs_ff});
		$display("test external boot done");
		conclude();
	end
endmodule
`default_nettype wire
